// ### hw/jos_map.svh
/*
  offsets, field positions, reset values and sizes of the output status
  register group; assumes a 32-bit APB slave with word-aligned registers
*/
`ifndef JOS_MAP_SVH
`define JOS_MAP_SVH

// register indices; byte address is four times the index
`define JOS_IDX_FLAGS     6'h02
`define JOS_IDX_LEN_LO    6'h03
`define JOS_IDX_FILL      6'h04

// fields of the flag register
`define JOS_BIT_DONE      0
`define JOS_BIT_OVF       1
`define JOS_BIT_SPOOF     2
`define JOS_BIT_ROB       3
`define JOS_BIT_WM_CLR    4
`define JOS_WM_LSB        4
`define JOS_QSEL_LSB      6
`define JOS_LENHI_LSB     8

// reset values
`define JOS_RST_FLAGS     16'h0000
`define JOS_RST_LEN       24'h000000
`define JOS_RST_FILL      3'h0
`define JOS_RST_STICKY    4'h0
`define JOS_RST_WM        2'h0

// output fifo size, fixed
`define JOS_FIFO_DEPTH    11'h400
`define JOS_FILL_W        11

// fill codes
`define JOS_FC_EMPTY      3'h0
`define JOS_FC_Q0         3'h1
`define JOS_FC_Q1         3'h3
`define JOS_FC_Q2         3'h2
`define JOS_FC_Q3         3'h6

`endif

// ### hw/jos_pkg.sv
/*
  types of the output status register group; assumes jos_map.svh
*/
package jos_pkg;

    // one-cycle event pulses from encoder, fifo and re-order buffer
    typedef struct packed {
        logic xferDone;
        logic fifoOvf;
        logic spoofOvs;
        logic robOvf;
        logic robUdf;
    } jos_evt_t;

    // sticky done and error flags of the first status register
    typedef struct packed {
        logic rob;
        logic spoof;
        logic ovf;
        logic done;
    } jos_flags_t;

    typedef enum logic [1:0] {
        QSET0,
        QSET1,
        QSET2,
        QRSVD
    } jos_qset_t;

endpackage

// ### hw/jos_fill_quant.sv
/*
  quantises a fifo fill count into quarters, registered;
  assumes the count never exceeds the fifo depth
*/
`timescale 1ns/10ps
`include "jos_map.svh"

module jos_fill_quant
#(
    parameter logic [`JOS_FILL_W-1:0] DEPTH = `JOS_FIFO_DEPTH
)
(
    // clock and reset
    input  wire logic                   ref_clk,
    input  wire logic                   reset,
    // fill count
    input  wire logic [`JOS_FILL_W-1:0] fill,
    // quarter index and non-empty flag
    output logic      [1:0]             quarter_q,
    output logic                        nonEmpty_q
);
    localparam logic [`JOS_FILL_W-1:0] QTR  = DEPTH >> 2;
    localparam logic [`JOS_FILL_W-1:0] HALF = DEPTH >> 1;
    localparam logic [`JOS_FILL_W-1:0] TQTR = QTR + HALF;

    logic [1:0] quarter_d;

    always_comb
    begin
        if (fill >= TQTR)
            quarter_d = 2'h3;
        else if (fill >= HALF)
            quarter_d = 2'h2;
        else if (fill >= QTR)
            quarter_d = 2'h1;
        else
            quarter_d = 2'h0;
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            quarter_q  <= 2'h0;
            nonEmpty_q <= 1'b0;
        end
        else
        begin
            quarter_q  <= quarter_d;
            nonEmpty_q <= (fill != '0);
        end
    end

endmodule

// ### hw/jos_status_regs.sv
/*
  status register group of the compressed-image output path: sticky
  flags, fifo watermark, quantisation set, 24-bit byte count, live
  fill code, reached over APB.
  assumes event inputs are one-cycle pulses synchronous to ref_clk and
  that the fifo fill count is synchronous too.
*/
//
// Function
// - transfer done sets sticky bit 0
// - write one to bit 0 clears it
// - clearing done also clears bits 1-3
// - clear only while output buffer clock runs
// - fifo overflow aborts transfer, sets bit 1
// - spoof size too small sets bit 2
// - re-order buffer over/underflow sets bit 3
// - bits 1-2 meaningful only when compressed
// - bits 5:4 hold sticky fifo watermark
// - write one to bit 4 reloads watermark with current quarter
// - bits 7:6 show quant set, 11 reserved
// - bits 15:8 hold byte count high byte
// - second register holds count bits 15:0
// - byte count freezes on fifo overflow
// - third register gives live fill code
`timescale 1ns/10ps
`include "jos_map.svh"

module jos_status_regs
(
    // clock and reset
    input  wire logic                   ref_clk,
    input  wire logic                   reset,
    // apb slave
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [7:0]             paddr,
    input  wire logic [31:0]            pwdata,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    // encoder, fifo and re-order buffer
    input  wire jos_pkg::jos_evt_t      evt,
    input  wire logic                   frameStart,
    input  wire logic                   byteSent,
    input  wire logic [`JOS_FILL_W-1:0] fifoFill,
    input  wire logic [1:0]             quant_table_set_sel,
    input  wire logic                   compressedMode,
    input  wire logic                   outBufClkRun,
    // transfer control
    output logic                        abortXfer
);
    import jos_pkg::*;

    jos_flags_t flags_q;
    jos_flags_t flags_d;
    logic [1:0]  wmark_q;
    jos_qset_t   qset_q;
    logic [23:0] byteCnt_q;
    logic        frozen_q;
    logic        frameAct_q;
    logic [2:0]  fillCode_q;
    logic        abort_q;
    logic [31:0] prdata_q;
    logic        pready_q;
    logic        pslverr_q;
    logic [1:0]  quarter;
    logic        nonEmpty;
    logic [5:0]  regIdx;
    logic        mapped;
    logic        wrDone;
    logic        clrDone;
    logic        clrWm;
    logic        ovfEvt;
    logic        spoofEvt;

    jos_fill_quant jos_fill_quant_inst
    (
        .ref_clk    (ref_clk),
        .reset      (reset),
        .fill       (fifoFill),
        .quarter_q  (quarter),
        .nonEmpty_q (nonEmpty)
    );

    // apb decode; one wait state so read data comes from a register
    assign regIdx  = paddr[7:2];
    assign mapped  = (regIdx == `JOS_IDX_FLAGS) ||
                     (regIdx == `JOS_IDX_LEN_LO) ||
                     (regIdx == `JOS_IDX_FILL);
    assign wrDone  = psel && penable && pready_q && pwrite && !pslverr_q;
    assign clrDone = wrDone && (regIdx == `JOS_IDX_FLAGS) &&
                     pwdata[`JOS_BIT_DONE] && outBufClkRun;
    assign clrWm   = wrDone && (regIdx == `JOS_IDX_FLAGS) &&
                     pwdata[`JOS_BIT_WM_CLR];

    // uncompressed modes never raise these; their meaning is undefined
    assign ovfEvt   = evt.fifoOvf && compressedMode;
    assign spoofEvt = evt.spoofOvs && compressedMode;

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h00000000;
        end
        else
        begin
            pready_q  <= psel && penable && !pready_q;
            pslverr_q <= psel && penable && !pready_q && !mapped;
            if (psel && penable && !pready_q && !pwrite)
            begin
                unique case (regIdx)
                    `JOS_IDX_FLAGS:
                        prdata_q <= {16'h0000, byteCnt_q[23:16],
                                     qset_q, wmark_q, flags_q};
                    `JOS_IDX_LEN_LO:
                        prdata_q <= {16'h0000, byteCnt_q[15:0]};
                    `JOS_IDX_FILL:
                        prdata_q <= {29'h00000000, fillCode_q};
                    default:
                        prdata_q <= 32'h00000000;
                endcase
            end
        end
    end

    // sticky flags: a set in the clearing cycle wins
    always_comb
    begin
        flags_d = flags_q;
        if (clrDone)
            flags_d = '0;
        if (evt.xferDone)
            flags_d.done = 1'b1;
        if (ovfEvt)
            flags_d.ovf = 1'b1;
        if (spoofEvt)
            flags_d.spoof = 1'b1;
        if (evt.robOvf || evt.robUdf)
            flags_d.rob = 1'b1;
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
            flags_q <= jos_flags_t'(`JOS_RST_STICKY);
        else
            flags_q <= flags_d;
    end

    // watermark remembers the highest quarter since last clear
    always_ff @(posedge ref_clk)
    begin
        if (reset)
            wmark_q <= `JOS_RST_WM;
        else if (clrWm)
            wmark_q <= quarter;
        else if (quarter > wmark_q)
            wmark_q <= quarter;
    end

    // reserved code is never shown; last legal set is kept
    always_ff @(posedge ref_clk)
    begin
        if (reset)
            qset_q <= QSET0;
        else if (quant_table_set_sel != QRSVD)
            qset_q <= jos_qset_t'(quant_table_set_sel);
    end

    // frame tracking and early end on overflow
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            frameAct_q <= 1'b0;
            abort_q    <= 1'b0;
        end
        else
        begin
            abort_q <= ovfEvt && frameAct_q;
            if (frameStart)
                frameAct_q <= 1'b1;
            else if (evt.xferDone || ovfEvt)
                frameAct_q <= 1'b0;
        end
    end

    // byte count restarts per frame and stops counting after overflow
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            byteCnt_q <= `JOS_RST_LEN;
            frozen_q  <= 1'b0;
        end
        else if (frameStart)
        begin
            byteCnt_q <= `JOS_RST_LEN;
            frozen_q  <= 1'b0;
        end
        else
        begin
            if (ovfEvt)
                frozen_q <= 1'b1;
            if (byteSent && !frozen_q && !ovfEvt)
                byteCnt_q <= byteCnt_q + 24'h000001;
        end
    end

    // fill code only takes the five listed values
    always_ff @(posedge ref_clk)
    begin
        if (reset)
            fillCode_q <= `JOS_RST_FILL;
        else if (!nonEmpty)
            fillCode_q <= `JOS_FC_EMPTY;
        else
        begin
            unique case (quarter)
                2'h0: fillCode_q <= `JOS_FC_Q0;
                2'h1: fillCode_q <= `JOS_FC_Q1;
                2'h2: fillCode_q <= `JOS_FC_Q2;
                2'h3: fillCode_q <= `JOS_FC_Q3;
            endcase
        end
    end

    assign prdata    = prdata_q;
    assign pready    = pready_q;
    assign pslverr   = pslverr_q;
    assign abortXfer = abort_q;

    // checks
    sequence s_setup;
        psel && !penable;
    endsequence

    sequence s_access;
        psel && penable && !pready_q;
    endsequence

    property p_apb_wait;
        @(posedge ref_clk) disable iff (reset)
        s_setup ##1 s_access |=> pready_q;
    endproperty
    a_apb_wait: assert property (p_apb_wait)
        else $error("pready not one cycle into access");

    property p_done_set;
        @(posedge ref_clk) disable iff (reset)
        evt.xferDone |=> flags_q.done;
    endproperty
    a_done_set: assert property (p_done_set)
        else $error("done flag not set");

    property p_done_hold;
        @(posedge ref_clk) disable iff (reset)
        flags_q.done && !clrDone |=> flags_q.done;
    endproperty
    a_done_hold: assert property (p_done_hold)
        else $error("done flag dropped without clear");

    property p_clr_all;
        @(posedge ref_clk) disable iff (reset)
        clrDone && !evt.xferDone && !evt.fifoOvf && !evt.spoofOvs &&
        !evt.robOvf && !evt.robUdf |=> flags_q == '0;
    endproperty
    a_clr_all: assert property (p_clr_all)
        else $error("clear left an error flag set");

    property p_clr_clk;
        @(posedge ref_clk) disable iff (reset)
        $fell(flags_q.done) |-> $past(outBufClkRun);
    endproperty
    a_clr_clk: assert property (p_clr_clk)
        else $error("done cleared with buffer clock stopped");

    property p_ovf_abort;
        @(posedge ref_clk) disable iff (reset)
        evt.fifoOvf && compressedMode && frameAct_q
            |=> abortXfer && flags_q.ovf ##1 !abortXfer;
    endproperty
    a_ovf_abort: assert property (p_ovf_abort)
        else $error("overflow did not end the transfer");

    property p_rob;
        @(posedge ref_clk) disable iff (reset)
        evt.robOvf || evt.robUdf |=> flags_q.rob;
    endproperty
    a_rob: assert property (p_rob)
        else $error("re-order error not flagged");

    property p_uncomp;
        @(posedge ref_clk) disable iff (reset)
        $rose(flags_q.spoof) |-> $past(compressedMode);
    endproperty
    a_uncomp: assert property (p_uncomp)
        else $error("spoof flag raised outside compressed mode");

    property p_wm_max;
        @(posedge ref_clk) disable iff (reset)
        !clrWm |=> wmark_q >= $past(quarter);
    endproperty
    a_wm_max: assert property (p_wm_max)
        else $error("watermark below level reached");

    property p_qset;
        @(posedge ref_clk) disable iff (reset)
        qset_q != QRSVD;
    endproperty
    a_qset: assert property (p_qset)
        else $error("reserved quant set shown");

    property p_freeze;
        @(posedge ref_clk) disable iff (reset)
        frozen_q && !frameStart |=> $stable(byteCnt_q);
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("byte count moved after overflow");

    property p_fill_code;
        @(posedge ref_clk) disable iff (reset)
        fillCode_q inside {`JOS_FC_EMPTY, `JOS_FC_Q0, `JOS_FC_Q1,
                           `JOS_FC_Q2, `JOS_FC_Q3};
    endproperty
    a_fill_code: assert property (p_fill_code)
        else $error("illegal fill code");

    property p_spoof_set;
        @(posedge ref_clk) disable iff (reset)
        spoofEvt |=> flags_q.spoof;
    endproperty
    a_spoof_set: assert property (p_spoof_set)
        else $error("spoof flag not set");

    property p_wm_clr;
        @(posedge ref_clk) disable iff (reset)
        clrWm |=> wmark_q == $past(quarter);
    endproperty
    a_wm_clr: assert property (p_wm_clr)
        else $error("watermark not reloaded on clear");

endmodule

// ### verif/test_jos_status_regs.sv
/*
  self-checking bench of the output status register group;
  assumes jos_pkg compiled first and jos_map.svh on the include path
*/
`timescale 1ns/10ps
`include "jos_map.svh"

module test_jos_status_regs;
import jos_pkg::*;

logic                   ref_clk = 1'b0;
logic                   reset = 1'b1;
logic                   psel = 1'b0;
logic                   penable = 1'b0;
logic                   pwrite = 1'b0;
logic [7:0]             paddr = 8'h00;
logic [31:0]            pwdata = 32'h0;
logic [31:0]            prdata;
logic                   pready;
logic                   pslverr;
jos_evt_t               evt = '0;
logic                   frameStart = 1'b0;
logic                   byteSent = 1'b0;
logic [`JOS_FILL_W-1:0] fifoFill = 11'h000;
logic [1:0]             qSel = 2'h0;
logic                   compressedMode = 1'b1;
logic                   outBufClkRun = 1'b1;
logic                   abortXfer;
logic [31:0]            rd;
logic                   errSeen;
int                     fails = 0;
int                     nTests = 0;
integer                 seed = 32'h0BDB;
int                     n;
int                     f;
int                     fills [10] = '{0, 1, 255, 256, 511, 512, 767, 768,
                                       1023, 1024};

always #2.5 ref_clk = ~ref_clk;

jos_status_regs jos_status_regs_inst
(
    .ref_clk             (ref_clk),
    .reset               (reset),
    .psel                (psel),
    .penable             (penable),
    .pwrite              (pwrite),
    .paddr               (paddr),
    .pwdata              (pwdata),
    .prdata              (prdata),
    .pready              (pready),
    .pslverr             (pslverr),
    .evt                 (evt),
    .frameStart          (frameStart),
    .byteSent            (byteSent),
    .fifoFill            (fifoFill),
    .quant_table_set_sel (qSel),
    .compressedMode      (compressedMode),
    .outBufClkRun        (outBufClkRun),
    .abortXfer           (abortXfer)
);

task stopTest;
    $display("comparisons %0d mismatches %0d", nTests, fails);
    if (fails == 0 && nTests > 0)
        $display("Testbench passed");
    else
        $display("Testbench failed");
    $finish;
endtask

task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    nTests++;
    if (seen !== exp)
    begin
        fails++;
        $display("unexpected %s: expected %0h seen %0h", name, exp, seen);
    end
endtask

// waits for pready at a rising edge; the watchdog cuts a hang short
task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    errSeen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
endtask

task ev(input jos_evt_t e);
    @(posedge ref_clk);
    evt <= e;
    @(posedge ref_clk);
    evt <= '0;
endtask

function automatic logic [2:0] fc(input int v);
    if (v == 0) return `JOS_FC_EMPTY;
    if (v < 256) return `JOS_FC_Q0;
    if (v < 512) return `JOS_FC_Q1;
    if (v < 768) return `JOS_FC_Q2;
    return `JOS_FC_Q3;
endfunction

function automatic logic [1:0] qt(input int v);
    return (v >= 768) ? 2'h3 : 2'(v / 256);
endfunction

initial
begin
    repeat (100000) @(posedge ref_clk);
    fails++;
    stopTest();
end

initial
begin
    repeat (12) @(posedge ref_clk);
    reset <= 1'b0;
    apb(0, 8'h08, 0);
    check("flags reset", rd, 32'h0);
    check("mapped no error", 32'(errSeen), 32'h0);
    apb(0, 8'h0C, 0);
    check("length reset", rd, 32'h0);
    apb(0, 8'h10, 0);
    check("fill reset", rd, 32'h0);
    apb(0, 8'h20, 0);
    check("unmapped error", 32'(errSeen), 32'h1);
    // count past 16 bits so the high byte is exercised
    n = 32'h10000 + ($random(seed) & 32'hFF);
    @(posedge ref_clk);
    frameStart <= 1'b1;
    @(posedge ref_clk);
    frameStart <= 1'b0;
    byteSent <= 1'b1;
    repeat (n) @(posedge ref_clk);
    byteSent <= 1'b0;
    evt <= 5'b01000;
    @(posedge ref_clk);
    evt <= '0;
    byteSent <= 1'b1;
    @(posedge ref_clk);
    check("abort pulse", 32'(abortXfer), 32'h1);
    @(posedge ref_clk);
    check("abort end", 32'(abortXfer), 32'h0);
    repeat (5) @(posedge ref_clk);
    byteSent <= 1'b0;
    apb(0, 8'h08, 0);
    check("overflow flag", rd & 32'hF, 32'h2);
    check("length high", (rd >> 8) & 32'hFF, 32'(n >> 16));
    apb(0, 8'h0C, 0);
    check("length low", rd, 32'(n & 32'hFFFF));
    ev(5'b00100);
    ev(5'b00001);
    ev(5'b10000);
    apb(0, 8'h08, 0);
    check("all flags", rd & 32'hF, 32'hF);
    @(posedge ref_clk);
    outBufClkRun <= 1'b0;
    apb(1, 8'h08, 32'h1);
    apb(0, 8'h08, 0);
    check("clear no clock", rd & 32'hF, 32'hF);
    outBufClkRun <= 1'b1;
    apb(1, 8'h08, 32'hFFFFFFEE);
    apb(0, 8'h08, 0);
    check("write zero", rd & 32'hF, 32'hF);
    apb(1, 8'h08, 32'h1);
    apb(0, 8'h08, 0);
    check("clear all", rd & 32'hF, 32'h0);
    ev(5'b00010);
    apb(0, 8'h08, 0);
    check("rob overflow", rd & 32'hF, 32'h8);
    apb(1, 8'h08, 32'h1);
    apb(0, 8'h08, 0);
    check("rob clear", rd & 32'hF, 32'h0);
    // overflow and spoof events carry no meaning outside compressed output
    compressedMode <= 1'b0;
    ev(5'b01100);
    apb(0, 8'h08, 0);
    check("uncompressed", rd & 32'hF, 32'h0);
    compressedMode <= 1'b1;
    // ascending fill, so the sticky watermark equals the live quarter
    foreach (fills[i])
    begin
        @(posedge ref_clk);
        fifoFill <= 11'(fills[i]);
        repeat (2) @(posedge ref_clk);
        apb(0, 8'h10, 0);
        check("fill code", rd, 32'(fc(fills[i])));
        apb(0, 8'h08, 0);
        check("watermark", (rd >> 4) & 32'h3, 32'(qt(fills[i])));
    end
    f = $random(seed) & 32'hFF;
    @(posedge ref_clk);
    fifoFill <= 11'(f);
    repeat (2) @(posedge ref_clk);
    apb(0, 8'h10, 0);
    check("fill low", rd, 32'(fc(f)));
    apb(0, 8'h08, 0);
    check("watermark held", (rd >> 4) & 32'h3, 32'h3);
    apb(1, 8'h08, 32'h10);
    apb(0, 8'h08, 0);
    check("watermark clear", (rd >> 4) & 32'h3, 32'(qt(f)));
    // code 11 is reserved, so set two stays shown
    for (int q = 0; q < 4; q++)
    begin
        @(posedge ref_clk);
        qSel <= 2'(q);
        apb(0, 8'h08, 0);
        check("quant set", (rd >> 6) & 32'h3, 32'(q == 3 ? 2 : q));
    end
    apb(1, 8'h0C, 32'hFFFFFFFF);
    apb(0, 8'h0C, 0);
    check("length ro", rd, 32'(n & 32'hFFFF));
    apb(1, 8'h10, 32'hFFFFFFFF);
    apb(0, 8'h10, 0);
    check("fill ro", rd, 32'(fc(f)));
    stopTest();
end

endmodule
